// ---- bmc_asserts.sv ----
/* Port checker for the basic mode control block.
   Assumes mdc runs two clk cycles high and two low. */
`timescale 1ns/100ps
`default_nettype none
module bmc_asserts (
	input wire logic clk,
	input wire logic reset,
	input wire logic mdio_out,
	input wire logic mdio_oe,
	input wire logic strap_an_enable,
	input wire logic fiber_mode_enable,
	input wire logic an_initiated,
	input wire logic an_speed_100,
	input wire logic an_full_duplex,
	input wire logic an_enable,
	input wire logic an_restart_req,
	input wire logic power_down,
	input wire logic op_speed_100,
	input wire logic op_full_duplex,
	input wire bmc_pkg::bmc_mii_t mii_tx,
	input wire bmc_pkg::bmc_mii_t mii_rx,
	input wire logic mii_col,
	input wire logic line_col
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Restart steps: pending, then seen by the engine
	sequence s_pend;
		an_restart_req && !an_initiated;
	endsequence
	sequence s_ack;
		an_restart_req && an_initiated;
	endsequence
	a_restart_gate: assert property ($rose(an_restart_req) |-> an_enable)
		else $error("restart raised with negotiation off");
	a_restart_hold: assert property (s_pend |=> an_restart_req)
		else $error("restart dropped early");
	a_restart_clear: assert property (s_ack |-> ##[1:2] !an_restart_req)
		else $error("restart not cleared");
	a_auto_mode: assert property ($past(an_enable) |-> op_speed_100 == $past(an_speed_100)
		&& op_full_duplex == $past(an_full_duplex))
		else $error("negotiated mode not used");
	a_power_quiet: assert property (power_down |=> mii_rx == bmc_pkg::MII_IDLE && !mii_col)
		else $error("port active in power down");
	a_col_drop: assert property (!mii_tx.valid && !line_col |=> !mii_col)
		else $error("collision held");
	a_col_cause: assert property ($rose(mii_col) |-> $past(mii_tx.valid) || $past(line_col))
		else $error("collision without cause");
	a_ta_drive: assert property ($rose(mdio_oe) |-> !mdio_out ##1 mdio_oe[*8])
		else $error("bad turnaround");
	// Seventeen mdc periods of four clk each from turnaround to release
	a_oe_release: assert property ($rose(mdio_oe) |-> ##68 (!mdio_oe && $past(mdio_oe)))
		else $error("read drive length wrong");
	a_strap_load: assert property ($fell(reset) |-> ##30
		an_enable == (strap_an_enable && !fiber_mode_enable))
		else $error("negotiation strap not loaded");
endmodule // bmc_asserts
`default_nettype wire

// ---- bmc_basic_mode_control.sv ----
/*
 * Basic mode control register of a 10/100 transceiver, with its serial
 * management slave, strap reload, loopback, isolate, power down,
 * forced mode resolution and collision test.
 * Assumes mdc and all other inputs are synchronous to clk, the
 * negotiation engine acknowledges a restart with an_initiated, and the
 * pad logic resolves mdio from mdio_out and mdio_oe.
 */
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Bit 15 starts reset, reads one meanwhile
// - Software reset reloads fields from straps
// - Loopback routes transmit data to receive
// - Loopback start hides receive data 500 us
// - Forced speed: one is 100, zero 10
// - Negotiation enable loads from strap, writable
// - Fiber mode forces negotiation enable off on strap reload only
// - Negotiation on ignores speed and duplex bits
// - Negotiation off: bits alone set mode
// - Power down stops all but registers
// - Isolate detaches interface, management still works
// - Restart bit restarts negotiation from start
// - Restart ignored while negotiation disabled
// - Restart reads one until negotiation initiated
// - Writing zero leaves running negotiation alone
// - Forced duplex: one full, zero half
// - Collision test raises col after tx_en
// - Collision test drops col after tx_en
// - Bits 6:0 ignore writes, read zero
// - Self-clearing bits drop when event ends
module bmc_basic_mode_control #(
	parameter int unsigned LOOPBACK_DEAD_CYCLES =
		bmc_pkg::LOOPBACK_DEAD_NS / bmc_pkg::CLK_PERIOD_NS
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [4:0] phy_address,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	input wire logic strap_speed_100,
	input wire logic strap_full_duplex,
	input wire logic strap_an_enable,
	input wire logic fiber_mode_enable,
	input wire logic an_initiated,
	input wire logic an_speed_100,
	input wire logic an_full_duplex,
	output logic an_enable,
	output logic an_restart_req,
	output logic power_down,
	output logic op_speed_100,
	output logic op_full_duplex,
	input wire bmc_pkg::bmc_mii_t mii_tx,
	output bmc_pkg::bmc_mii_t mii_rx,
	output logic mii_col,
	input wire bmc_pkg::bmc_mii_t line_rx,
	input wire logic line_col,
	output bmc_pkg::bmc_mii_t line_tx
);

	// Serial management receiver state
	bmc_pkg::bmc_mdio_state_t state_ff;
	bmc_pkg::bmc_mdio_state_t nxt_state;
	logic mdc_q_ff;
	logic [3:0] cnt_ff;
	logic [3:0] nxt_cnt;
	logic [11:0] hdr_ff;
	logic [11:0] nxt_hdr;
	logic [15:0] sr_ff;
	logic [15:0] nxt_sr;
	logic own_ff;
	logic nxt_own;
	logic is_read_ff;
	logic nxt_is_read;
	logic mdio_out_ff;
	logic nxt_mdio_out;
	logic mdio_oe_ff;
	logic nxt_mdio_oe;

	// Register and its side state
	bmc_pkg::bmc_ctrl_t ctrl_ff;
	bmc_pkg::bmc_ctrl_t nxt_ctrl;
	logic [7:0] swrst_cnt_ff;
	logic [7:0] nxt_swrst_cnt;
	logic [16:0] dead_cnt_ff;
	logic [16:0] nxt_dead_cnt;

	// Datapath and mode outputs
	bmc_pkg::bmc_mii_t mii_rx_ff;
	bmc_pkg::bmc_mii_t nxt_mii_rx;
	bmc_pkg::bmc_mii_t line_tx_ff;
	bmc_pkg::bmc_mii_t nxt_line_tx;
	logic col_ff;
	logic nxt_col;
	logic speed_ff;
	logic nxt_speed;
	logic duplex_ff;
	logic nxt_duplex;

	// Frame decode
	wire mdc_rise = mdc & ~mdc_q_ff;
	wire [12:0] hdr_full = {hdr_ff, mdio_in};
	wire hdr_start_ok = hdr_full[12];
	wire [1:0] hdr_op = hdr_full[11:10];
	wire [4:0] hdr_phy = hdr_full[9:5];
	wire [4:0] hdr_reg = hdr_full[4:0];
	wire hdr_op_ok = (hdr_op == bmc_pkg::OP_READ) | (hdr_op == bmc_pkg::OP_WRITE);
	wire hdr_own = (hdr_phy == phy_address) & (hdr_reg == bmc_pkg::REG_ADDR_BMC);
	wire last_bit = (cnt_ff == 4'h0);
	wire [15:0] wdata = {sr_ff[14:0], mdio_in};
	wire wr_fire = mdc_rise & (state_ff == bmc_pkg::MDIO_WR) & last_bit & own_ff;

	// Register view and write effects
	wire [15:0] rd_value = {ctrl_ff[15:7], 7'h00};
	wire swrst_busy = (swrst_cnt_ff != 8'h00);
	wire wr_reset = wr_fire & wdata[bmc_pkg::BIT_RESET];
	wire restart_set = wr_fire & wdata[bmc_pkg::BIT_RESTART] & wdata[bmc_pkg::BIT_AN_EN];
	wire lb_rise = ~ctrl_ff.loopback & nxt_ctrl.loopback;
	wire dead = (dead_cnt_ff != 17'h00000);
	wire quiet = ctrl_ff.isolate | ctrl_ff.power_down;

	// Serial management frame walker, stepping on each mdc rising edge
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_hdr = hdr_ff;
		nxt_sr = sr_ff;
		nxt_own = own_ff;
		nxt_is_read = is_read_ff;
		nxt_mdio_out = mdio_out_ff;
		nxt_mdio_oe = mdio_oe_ff;
		if (mdc_rise)
		begin
			case (state_ff)
				bmc_pkg::MDIO_IDLE:
				begin
					nxt_mdio_oe = 1'b0;
					// First zero after idle ones opens a frame
					if (!mdio_in)
					begin
						nxt_state = bmc_pkg::MDIO_HDR;
						nxt_cnt = bmc_pkg::HDR_BITS_LEFT;
						nxt_hdr = 12'h000;
					end
				end
				bmc_pkg::MDIO_HDR:
				begin
					nxt_hdr = hdr_full[11:0];
					nxt_cnt = cnt_ff - 4'h1;
					if (last_bit)
					begin
						nxt_own = hdr_own;
						nxt_is_read = (hdr_op == bmc_pkg::OP_READ);
						nxt_cnt = bmc_pkg::TA_BITS_LEFT;
						// Bad start or opcode drops back to hunting
						nxt_state = (hdr_start_ok & hdr_op_ok) ?
							bmc_pkg::MDIO_TA : bmc_pkg::MDIO_IDLE;
					end
				end
				bmc_pkg::MDIO_TA:
				begin
					nxt_cnt = cnt_ff - 4'h1;
					if (!last_bit)
					begin
						// Second turnaround bit is driven low on reads
						nxt_mdio_oe = own_ff & is_read_ff;
						nxt_mdio_out = 1'b0;
					end
					else
					begin
						nxt_cnt = bmc_pkg::DATA_BITS_LEFT;
						nxt_state = is_read_ff ? bmc_pkg::MDIO_RD : bmc_pkg::MDIO_WR;
						nxt_mdio_out = rd_value[15];
						nxt_sr = {rd_value[14:0], 1'b0};
					end
				end
				bmc_pkg::MDIO_RD:
				begin
					nxt_cnt = cnt_ff - 4'h1;
					nxt_mdio_out = sr_ff[15];
					nxt_sr = {sr_ff[14:0], 1'b0};
					if (last_bit)
					begin
						nxt_mdio_oe = 1'b0;
						nxt_state = bmc_pkg::MDIO_IDLE;
					end
				end
				bmc_pkg::MDIO_WR:
				begin
					nxt_cnt = cnt_ff - 4'h1;
					nxt_sr = wdata;
					if (last_bit)
					begin
						nxt_state = bmc_pkg::MDIO_IDLE;
					end
				end
				default:
				begin
					nxt_state = bmc_pkg::MDIO_IDLE;
					nxt_mdio_oe = 1'b0;
				end
			endcase
		end
	end

	// Register next value; strap reload holds for the whole reset process
	always_comb
	begin
		nxt_ctrl = ctrl_ff;
		nxt_swrst_cnt = swrst_cnt_ff;
		if (swrst_busy)
		begin
			nxt_swrst_cnt = swrst_cnt_ff - 8'h01;
			nxt_ctrl = bmc_pkg::CTRL_RESET;
			nxt_ctrl.reset_busy = (swrst_cnt_ff != 8'h01);
			nxt_ctrl.speed_100 = strap_speed_100;
			nxt_ctrl.full_duplex = strap_full_duplex;
			nxt_ctrl.an_enable = strap_an_enable & ~fiber_mode_enable;
		end
		else if (wr_reset)
		begin
			nxt_swrst_cnt = 8'(bmc_pkg::SWRST_CYCLES);
			nxt_ctrl.reset_busy = 1'b1;
		end
		else
		begin
			if (wr_fire)
			begin
				nxt_ctrl.loopback = wdata[bmc_pkg::BIT_LOOPBACK];
				nxt_ctrl.speed_100 = wdata[bmc_pkg::BIT_SPEED];
				nxt_ctrl.an_enable = wdata[bmc_pkg::BIT_AN_EN];
				nxt_ctrl.power_down = wdata[bmc_pkg::BIT_POWER_DOWN];
				nxt_ctrl.isolate = wdata[bmc_pkg::BIT_ISOLATE];
				nxt_ctrl.full_duplex = wdata[bmc_pkg::BIT_DUPLEX];
				nxt_ctrl.col_test = wdata[bmc_pkg::BIT_COL_TEST];
			end
			// Set wins over the acknowledge; a written zero never clears it
			nxt_ctrl.restart_an = restart_set | (ctrl_ff.restart_an & ~an_initiated);
		end
		nxt_ctrl.reserved = 7'h00;
	end

	// Loopback dead time: receive stays empty after loopback turns on
	always_comb
	begin
		nxt_dead_cnt = dead_cnt_ff;
		if (lb_rise)
		begin
			nxt_dead_cnt = 17'(LOOPBACK_DEAD_CYCLES);
		end
		else if (dead)
		begin
			nxt_dead_cnt = dead_cnt_ff - 17'h00001;
		end
	end

	// Receive side: loopback, isolate and power down selection
	always_comb
	begin
		nxt_mii_rx = ctrl_ff.loopback ? mii_tx : line_rx;
		if (ctrl_ff.loopback & dead)
		begin
			nxt_mii_rx = bmc_pkg::MII_IDLE;
		end
		if (quiet)
		begin
			nxt_mii_rx = bmc_pkg::MII_IDLE;
		end
		// Looped frames do not go out on the line
		nxt_line_tx = (quiet | ctrl_ff.loopback) ? bmc_pkg::MII_IDLE : mii_tx;
	end

	// Collision test follows tx_en one cycle later, well inside the limits
	assign nxt_col = ~quiet & ((ctrl_ff.col_test & mii_tx.valid) | (~ctrl_ff.loopback & line_col));

	// Operating mode resolution
	assign nxt_speed = ctrl_ff.an_enable ? an_speed_100 : ctrl_ff.speed_100;
	assign nxt_duplex = ctrl_ff.an_enable ? an_full_duplex : ctrl_ff.full_duplex;

	// Management receiver flops
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_ff <= bmc_pkg::MDIO_IDLE;
			mdc_q_ff <= 1'b1; // Idle high, so no false rise after reset
			cnt_ff <= 4'h0;
			hdr_ff <= 12'h000;
			sr_ff <= 16'h0000;
			own_ff <= 1'b0;
			is_read_ff <= 1'b0;
			mdio_out_ff <= 1'b0;
			mdio_oe_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			state_ff <= nxt_state;
			mdc_q_ff <= mdc;
			cnt_ff <= nxt_cnt;
			hdr_ff <= nxt_hdr;
			sr_ff <= nxt_sr;
			own_ff <= nxt_own;
			is_read_ff <= nxt_is_read;
			mdio_out_ff <= nxt_mdio_out;
			mdio_oe_ff <= nxt_mdio_oe;
		end
	end

	// Register flops; hardware reset runs the same strap reload as software
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ctrl_ff <= bmc_pkg::CTRL_RESET;
			swrst_cnt_ff <= 8'(bmc_pkg::SWRST_CYCLES);
			dead_cnt_ff <= 17'h00000;
		end
		else if (clk_en)
		begin
			ctrl_ff <= nxt_ctrl;
			swrst_cnt_ff <= nxt_swrst_cnt;
			dead_cnt_ff <= nxt_dead_cnt;
		end
	end

	// Datapath and mode flops
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			mii_rx_ff <= bmc_pkg::MII_IDLE;
			line_tx_ff <= bmc_pkg::MII_IDLE;
			col_ff <= 1'b0;
			speed_ff <= 1'b0;
			duplex_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			mii_rx_ff <= nxt_mii_rx;
			line_tx_ff <= nxt_line_tx;
			col_ff <= nxt_col;
			speed_ff <= nxt_speed;
			duplex_ff <= nxt_duplex;
		end
	end

	// Outputs straight from flops
	assign mdio_out = mdio_out_ff;
	assign mdio_oe = mdio_oe_ff;
	assign an_enable = ctrl_ff.an_enable;
	assign an_restart_req = ctrl_ff.restart_an;
	assign power_down = ctrl_ff.power_down;
	assign op_speed_100 = speed_ff;
	assign op_full_duplex = duplex_ff;
	assign mii_rx = mii_rx_ff;
	assign mii_col = col_ff;
	assign line_tx = line_tx_ff;

endmodule // bmc_basic_mode_control

`default_nettype wire

// ---- bmc_basic_mode_control_tb.sv ----
/* Self-checking bench for the basic mode control block.
   Assumes the station model and the port checker beside it. */
`timescale 1ns/100ps
`default_nettype none
module bmc_basic_mode_control_tb;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic sp, fd, an, fb, an_sp, an_fd, oe_q;
	logic an_init = 1'b0;
	logic mdc, mdio_in, mdio_out, mdio_oe, an_enable, an_restart_req, power_down;
	logic op_speed_100, op_full_duplex, mii_col;
	logic [15:0] rd_word, w;
	logic [15:0] exp_q[$];
	bmc_pkg::bmc_mii_t tx, rx_line, t, u, mii_rx, line_tx;
	integer seed = 12;
	int miscompares = 0;
	int num_checks = 0;
	bmc_basic_mode_control #(.LOOPBACK_DEAD_CYCLES(50)) i_dut (.clk, .reset, .clk_en(1'b1),
		.phy_address(5'h05), .mdc, .mdio_in, .mdio_out, .mdio_oe, .strap_speed_100(sp),
		.strap_full_duplex(fd), .strap_an_enable(an), .fiber_mode_enable(fb),
		.an_initiated(an_init), .an_speed_100(an_sp), .an_full_duplex(an_fd), .an_enable,
		.an_restart_req, .power_down, .op_speed_100, .op_full_duplex, .mii_tx(tx), .mii_rx,
		.mii_col, .line_rx(rx_line), .line_col(1'b0), .line_tx);
	bmc_mgmt_master i_mac (.clk, .mdio_out, .mdio_oe, .mdc, .mdio_in, .rd_word);
	always #2.5 clk = ~clk;
	// Fresh traffic every cycle keeps the datapath busy
	always @(posedge clk)
	begin
		tx <= 6'($random(seed));
		rx_line <= 6'($random(seed));
		an_sp <= 1'($random(seed));
		an_fd <= 1'($random(seed));
	end
	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1)
		begin
			miscompares++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	// A read ends when the device lets go of mdio
	always @(posedge clk)
	begin
		oe_q <= mdio_oe;
		if (oe_q && !mdio_oe)
			chk(exp_q.size() > 0 && rd_word === exp_q.pop_front(), "read word");
	end
	task automatic rd(input logic [15:0] e);
		exp_q.push_back(e);
		i_mac.xfer(1'b0, 5'h05, 16'h0000);
	endtask
	function automatic logic [15:0] strap_word();
		return {2'b00, sp, an & ~fb, 3'b000, fd, 8'h00};
	endfunction
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic wrap_up;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Watchdog: a hang counts as a mismatch
	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		wrap_up;
	end
	initial
	begin
		oe_q <= 1'b0;
		{sp, fd, an, fb} <= 4'($random(seed));
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		rd(strap_word());
		i_mac.xfer(1'b1, 5'h06, 16'hFFFF);
		rd(strap_word());
		for (int i = 0; i < 4; i++)
		begin
			w = (16'($random(seed)) & 16'h2FFF) | (i == 1 ? 16'h0A00 : 16'h0000);
			i_mac.xfer(1'b1, 5'h05, w);
			settle();
			chk(op_speed_100 === w[13] && op_full_duplex === w[8], "forced mode");
			chk(power_down === w[11] && an_restart_req === 1'b0, "pd or restart");
			if (w[11] || w[10])
			begin
				chk(mii_rx === bmc_pkg::MII_IDLE, "quiet port");
				chk(line_tx === bmc_pkg::MII_IDLE, "quiet line");
			end
			else
			begin
				t = rx_line;
				u = tx;
				@(posedge clk);
				#1;
				chk(mii_rx === t && line_tx === u, "line path");
			end
			rd(w & 16'h2D80);
		end
		i_mac.xfer(1'b1, 5'h05, 16'h1200);
		settle();
		chk(an_restart_req === 1'b1 && an_enable === 1'b1, "restart request");
		rd(16'h1200);
		i_mac.xfer(1'b1, 5'h05, 16'h1000);
		settle();
		chk(an_restart_req === 1'b1, "restart kept");
		@(posedge clk) an_init <= 1'b1;
		@(posedge clk) an_init <= 1'b0;
		settle();
		chk(an_restart_req === 1'b0, "restart cleared");
		rd(16'h1000);
		i_mac.xfer(1'b1, 5'h05, 16'h4080);
		repeat (2) @(posedge clk);
		repeat (40)
		begin
			@(posedge clk);
			#1;
			chk(mii_rx === bmc_pkg::MII_IDLE, "dead time");
		end
		repeat (20) @(posedge clk);
		#1;
		repeat (20)
		begin
			t = tx;
			@(posedge clk);
			#1;
			chk(mii_rx === t && mii_col === t.valid, "loop or collision");
			chk(line_tx === bmc_pkg::MII_IDLE, "line quiet in loop");
		end
		@(posedge clk);
		fb <= 1'b1;
		an <= 1'b1;
		i_mac.xfer(1'b1, 5'h05, 16'hCC80);
		rd(strap_word());
		chk(an_enable === 1'b0, "fiber forces manual");
		repeat (5) @(posedge clk);
		chk(exp_q.size() === 0, "reads answered");
		wrap_up;
	end
endmodule // bmc_basic_mode_control_tb
bind bmc_basic_mode_control bmc_asserts i_chk (.clk, .reset, .mdio_out, .mdio_oe,
	.strap_an_enable, .fiber_mode_enable, .an_initiated, .an_speed_100, .an_full_duplex,
	.an_enable, .an_restart_req, .power_down, .op_speed_100, .op_full_duplex, .mii_tx,
	.mii_rx, .mii_col, .line_col);
`default_nettype wire

// ---- bmc_mgmt_master.sv ----
/* Management station model: sends frames on mdc and mdio.
   Assumes mdio carries a pull-up while nobody drives it. */
`timescale 1ns/100ps
`default_nettype none
module bmc_mgmt_master (
	input wire logic clk,
	input wire logic mdio_out,
	input wire logic mdio_oe,
	output logic mdc,
	output logic mdio_in,
	output logic [15:0] rd_word
);
	logic drv;
	logic bit_v;
	// Wire level: station, then device, else the pull-up
	assign mdio_in = drv ? bit_v : (mdio_oe ? mdio_out : 1'b1);
	initial
	begin
		mdc = 1'b0;
		drv = 1'b0;
		bit_v = 1'b0;
		rd_word = 16'h0000;
	end
	// One frame; mdc stands still high between frames
	task automatic xfer(input logic wr, input logic [4:0] pa, input logic [15:0] wd);
		logic [33:0] f;
		f = {4'hD, wr ? bmc_pkg::OP_WRITE : bmc_pkg::OP_READ, pa, bmc_pkg::REG_ADDR_BMC,
			2'h2, wd};
		for (int i = 33; i >= 0; i--)
		begin
			@(posedge clk);
			mdc <= 1'b0;
			drv <= wr || i > 17;
			bit_v <= f[i];
			@(posedge clk);
			@(posedge clk);
			mdc <= 1'b1;
			rd_word <= {rd_word[14:0], mdio_in};
			@(posedge clk);
		end
		drv <= 1'b0;
	endtask
endmodule // bmc_mgmt_master
`default_nettype wire

// ---- bmc_pkg.sv ----
/*
 * Constants and types for the basic mode control register block.
 * Assumes a 200 MHz management-domain clock and one 16-bit register
 * reached over serial management frames at register address zero.
 */
`default_nettype none

package bmc_pkg;

	// Clock and timing
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned LOOPBACK_DEAD_NS = 500000;
	localparam int unsigned SWRST_TIME_NS = 100;
	localparam int unsigned SWRST_CYCLES = (SWRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Register address and field positions
	localparam logic [4:0] REG_ADDR_BMC = 5'h00;
	localparam int unsigned BIT_RESET = 15;
	localparam int unsigned BIT_LOOPBACK = 14;
	localparam int unsigned BIT_SPEED = 13;
	localparam int unsigned BIT_AN_EN = 12;
	localparam int unsigned BIT_POWER_DOWN = 11;
	localparam int unsigned BIT_ISOLATE = 10;
	localparam int unsigned BIT_RESTART = 9;
	localparam int unsigned BIT_DUPLEX = 8;
	localparam int unsigned BIT_COL_TEST = 7;

	// Management frame fields
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [3:0] HDR_BITS_LEFT = 4'hC;
	localparam logic [3:0] TA_BITS_LEFT = 4'h1;
	localparam logic [3:0] DATA_BITS_LEFT = 4'hF;

	// Basic mode control register layout
	typedef struct packed {
		logic reset_busy;
		logic loopback;
		logic speed_100;
		logic an_enable;
		logic power_down;
		logic isolate;
		logic restart_an;
		logic full_duplex;
		logic col_test;
		logic [6:0] reserved;
	} bmc_ctrl_t;

	localparam bmc_ctrl_t CTRL_RESET = 16'h8000;

	// Nibble-wide media independent interface group
	typedef struct packed {
		logic valid;
		logic error;
		logic [3:0] data;
	} bmc_mii_t;

	localparam bmc_mii_t MII_IDLE = 6'h00;

	// Serial management receiver states
	typedef enum logic [4:0] {
		MDIO_IDLE = 5'b00001,
		MDIO_HDR = 5'b00010,
		MDIO_TA = 5'b00100,
		MDIO_RD = 5'b01000,
		MDIO_WR = 5'b10000
	} bmc_mdio_state_t;

endpackage

`default_nettype wire
